// >>> bench/pit_cpu.sv
// Processor-side model: an APB master that issues register accesses.
// Assumes the slave ends every access with pready; hung marks a stuck wait.
module pit_cpu
	import pit_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [PIT_AW-1:0] paddr,
	output logic [PIT_DW-1:0] pwdata,
	input wire logic [PIT_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hung = 1'b0;
	logic [PIT_DW-1:0] dr;
	logic de;

	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// ************************************************************
	// One transfer: setup, then access until pready at an edge
	// ************************************************************
	task automatic xfer(input logic w, input logic [PIT_IW-1:0] ix,
		input logic [PIT_DW-1:0] d, output logic [PIT_DW-1:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		// Reads carry junk data so a slave never sees a stale word
		pwdata <= w ? d : ~d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		hung = hung | (n >= 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~pwdata;
	endtask

	task automatic prog(input logic [PIT_IW-1:0] ni, input logic [PIT_DW-1:0] lim,
		input logic [PIT_DW-1:0] flg, input logic [PIT_DW-1:0] cnt);
		xfer(1'b1, ni + 10'h001, 32'h0, dr, de);
		xfer(1'b1, ni + 10'h002, lim, dr, de);
		xfer(1'b1, ni + 10'h001, flg, dr, de);
		xfer(1'b1, ni, cnt, dr, de);
	endtask

	task automatic ack(input logic [PIT_IW-1:0] ni, input logic [PIT_DW-1:0] flg);
		xfer(1'b1, ni + 10'h001, flg, dr, de);
	endtask
endmodule

// >>> bench/processor_interval_timers_test.sv
// Self-checking bench for the two interval timers behind APB.
// Assumes pit_cpu stands for the processor; the xorshift seed is fixed.
module processor_interval_timers_test
	import pit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic cpu_halted, dbg_access, ev, seen_irq, seen_wd;
	logic [PIT_AW-1:0] paddr;
	logic [PIT_DW-1:0] pwdata, prdata, rv, v, c;
	logic [1:0] irq, wdt_rst;
	logic [31:0] seed = 32'hB1CC;
	logic [31:0] lim;
	logic [PIT_IW-1:0] nx [2] = '{PIT_T0_COUNT_IDX, PIT_T1_COUNT_IDX};
	int bad_count = 0;
	int tests_run = 0;
	int n;

	pit_top i_pit_top (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_halted(cpu_halted),
		.dbg_access(dbg_access), .irq(irq), .wdt_rst(wdt_rst));
	pit_cpu i_pit_cpu (.core_clk(core_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] xorshift();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic conclude();
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		tests_run++;
		if (got !== want) begin
			bad_count++;
			$display("Error at %0t: got %h, expected %h", $time, got, want);
		end
	endtask

	task automatic acc(input logic w, input logic [PIT_IW-1:0] ix, input logic [31:0] d);
		i_pit_cpu.xfer(w, ix, d, rv, ev);
		if (i_pit_cpu.hung) begin
			bad_count++;
			conclude();
		end
	endtask

	// Bounded wait for one output of timer t, noting both on the way
	task automatic await(input int t, input logic wd);
		seen_irq = 1'b0;
		seen_wd = 1'b0;
		n = 0;
		while ((wd ? wdt_rst[t] : irq[t]) !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
			seen_irq |= irq[t];
			seen_wd |= wdt_rst[t];
		end
	endtask

	task automatic drive(input logic h, input logic d);
		@(posedge core_clk);
		cpu_halted <= h;
		dbg_access <= d;
	endtask

	// Clock of 50 ns period
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		arst_n = 1'b0;
		cpu_halted = 1'b0;
		dbg_access = 1'b0;
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		// Unmapped index answers with an error and zero data
		acc(1'b0, 10'h3FF, 32'h0);
		cmp(32'(ev), 32'h1);
		cmp(rv, 32'h0);
		for (int t = 0; t < 2; t++) begin
			acc(1'b0, nx[t] + 10'h002, 32'h0);
			cmp(rv, PIT_LIMIT_RST);
			acc(1'b0, nx[t] + 10'h001, 32'h0);
			cmp(rv, 32'h0);
			for (int k = 0; k < 3; k++) begin
				v = xorshift();
				acc(1'b1, nx[t] + 10'h002, v);
				acc(1'b0, nx[t] + 10'h002, 32'h0);
				cmp(rv, v);
			end
			lim = 32'd16 + (xorshift() & 32'hF);
			// Enable clear: several wraps pass and nothing fires
			i_pit_cpu.prog(nx[t], lim, 32'h0, 32'h0);
			await(t, 1'b0);
			cmp(32'(n), 32'd400);
			cmp({30'h0, seen_irq, seen_wd}, 32'h0);
			drive(1'b0, 1'b1);
			acc(1'b0, nx[t], 32'h0);
			cmp(32'(rv <= lim), 32'h1);
			v = xorshift();
			acc(1'b1, nx[t], v);
			acc(1'b0, nx[t], 32'h0);
			cmp(rv, v);
			acc(1'b1, nx[t] + 10'h001, 32'h2);
			drive(1'b1, 1'b0);
			acc(1'b0, nx[t], 32'h0);
			cmp(rv, v);
			drive(1'b0, 1'b0);
			acc(1'b0, nx[t], 32'h0);
			cmp(32'(rv === v), 32'h0);
			// Watchdog with enable also set: pulse only, one cycle on.
			// Frozen while programming so no hit lands before the count write.
			drive(1'b0, 1'b1);
			i_pit_cpu.prog(nx[t], lim, 32'h5, 32'h0);
			drive(1'b0, 1'b0);
			await(t, 1'b1);
			cmp(32'(n), lim + 32'd3);
			cmp(32'(seen_irq), 32'h0);
			@(posedge core_clk);
			cmp(32'(wdt_rst[t]), 32'h0);
			drive(1'b0, 1'b1);
			i_pit_cpu.prog(nx[t], lim, 32'h1, 32'h0);
			drive(1'b0, 1'b0);
			await(t, 1'b0);
			cmp(32'(n), lim + 32'd2);
			cmp(32'(seen_wd), 32'h0);
			repeat (lim) @(posedge core_clk);
			cmp(32'(irq[t]), 32'h1);
			acc(1'b0, nx[t] + 10'h001, 32'h0);
			cmp(rv, 32'h9);
			// Freeze first so a fresh hit cannot race the clear
			drive(1'b0, 1'b1);
			acc(1'b0, nx[t], 32'h0);
			c = rv;
			i_pit_cpu.ack(nx[t], 32'h1);
			@(posedge core_clk);
			cmp(32'(irq[t]), 32'h0);
			acc(1'b0, nx[t], 32'h0);
			cmp(rv, c);
			acc(1'b0, nx[t] + 10'h001, 32'h0);
			cmp(rv, 32'h1);
			drive(1'b0, 1'b0);
		end
		conclude();
	end

	// Overall limit on run length
	initial begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		conclude();
	end
endmodule

// >>> src/pit_chan.sv
// Count register and limit compare of one timer.
// Assumes tick, load and limit come from logic on the same clock.
module pit_chan
	import pit_pkg::*;
#(
	parameter int DW = PIT_DW
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Control
	input wire logic tick,
	input wire logic load,
	input wire logic [DW-1:0] load_value,
	input wire logic [DW-1:0] limit,
	// State
	output logic [DW-1:0] count,
	output logic hit
);

	// Limit reached on a counting cycle
	assign hit = tick && (count == limit);

	// A load overrides counting so software always wins the race
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			count <= PIT_COUNT_RST;
		end else if (load) begin
			count <= load_value;
		end else if (hit) begin
			count <= PIT_COUNT_RST;
		end else if (tick) begin
			count <= DW'(count + 1'b1);
		end
	end

endmodule

// >>> src/pit_pkg.sv
// Shared constants and types for the two processor interval timers.
// Assumes a 32-bit APB slave port with word-indexed register numbers.
package pit_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int PIT_NUM = 2;
	localparam int PIT_DW = 32;
	localparam int PIT_AW = 12;
	localparam int PIT_IW = 10;

	// ************************************************************
	// Register indexes (byte address is four times the index)
	// ************************************************************
	localparam logic [PIT_IW-1:0] PIT_T0_COUNT_IDX = 10'h021;
	localparam logic [PIT_IW-1:0] PIT_T0_CTRL_IDX = 10'h022;
	localparam logic [PIT_IW-1:0] PIT_T0_LIMIT_IDX = 10'h023;
	localparam logic [PIT_IW-1:0] PIT_T1_COUNT_IDX = 10'h100;
	localparam logic [PIT_IW-1:0] PIT_T1_CTRL_IDX = 10'h101;
	localparam logic [PIT_IW-1:0] PIT_T1_LIMIT_IDX = 10'h102;

	// ************************************************************
	// Control field positions
	// ************************************************************
	localparam int PIT_IE_BIT = 0;
	localparam int PIT_NH_BIT = 1;
	localparam int PIT_WD_BIT = 2;
	localparam int PIT_IP_BIT = 3;

	// ************************************************************
	// Reset values and timing
	// ************************************************************
	localparam logic [PIT_DW-1:0] PIT_COUNT_RST = 32'h0000_0000;
	localparam logic [PIT_DW-1:0] PIT_LIMIT_RST = 32'h00FF_FFFF;
	localparam logic [PIT_DW-1:0] PIT_RD_ZERO = 32'h0000_0000;
	// Watchdog request follows the limit hit by this many cycles
	localparam int PIT_WD_DELAY = 2;

	// Control flags of one timer
	typedef struct packed {
		logic wd;
		logic nh;
		logic ie;
	} pit_ctrl_t;

	localparam pit_ctrl_t PIT_CTRL_RST = '{wd: 1'b0, nh: 1'b0, ie: 1'b0};

endpackage

// >>> src/pit_top.sv
// Two independent 32-bit up-counting timers behind an APB slave.
// Assumes core_clk keeps running while the processor sleeps and that
// cpu_halted and dbg_access come from core logic on the same clock.
module pit_top
	import pit_pkg::*;
#(
	parameter int NUM = PIT_NUM
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PIT_AW-1:0] paddr,
	input wire logic [PIT_DW-1:0] pwdata,
	output logic [PIT_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor status
	input wire logic cpu_halted,
	input wire logic dbg_access,
	// Timer outputs
	output logic [NUM-1:0] irq,
	output logic [NUM-1:0] wdt_rst
);

	// ************************************************************
	// APB transfer phases
	// ************************************************************

	logic acc_done;
	logic [PIT_IW-1:0] idx;
	logic wr_done;
	logic rd_phase;

	// Each access takes one wait state; writes land at the pready edge
	assign acc_done = psel && penable && pready;
	assign wr_done = acc_done && pwrite;
	assign rd_phase = psel && penable && !pready;
	assign idx = paddr[PIT_AW-1:2];

	// ************************************************************
	// Per-timer state
	// ************************************************************

	pit_ctrl_t ctrl [NUM];
	logic [PIT_DW-1:0] limit [NUM];
	logic [PIT_DW-1:0] count [NUM];
	logic [NUM-1:0] hit;
	logic [NUM-1:0] tick;
	logic [NUM-1:0] cnt_wr;
	logic [NUM-1:0] ctl_wr;
	logic [NUM-1:0] lim_wr;
	logic [NUM-1:0] cnt_sel;
	logic [NUM-1:0] ctl_sel;
	logic [NUM-1:0] lim_sel;

	genvar ch;
	generate
		for (ch = 0; ch < NUM; ch++) begin : g_tmr
			logic [PIT_WD_DELAY-1:0] wd_pipe;
			logic irq_set;

			// Register indexes differ only by timer
			assign cnt_sel[ch] = (idx == ((ch == 0) ? PIT_T0_COUNT_IDX : PIT_T1_COUNT_IDX));
			assign ctl_sel[ch] = (idx == ((ch == 0) ? PIT_T0_CTRL_IDX : PIT_T1_CTRL_IDX));
			assign lim_sel[ch] = (idx == ((ch == 0) ? PIT_T0_LIMIT_IDX : PIT_T1_LIMIT_IDX));
			assign cnt_wr[ch] = wr_done && cnt_sel[ch];
			assign ctl_wr[ch] = wr_done && ctl_sel[ch];
			assign lim_wr[ch] = wr_done && lim_sel[ch];

			assign tick[ch] = !dbg_access && !(ctrl[ch].nh && cpu_halted);

			pit_chan #(
				.DW(PIT_DW)
			) u_chan (
				.core_clk(core_clk),
				.arst_n(arst_n),
				.tick(tick[ch]),
				.load(cnt_wr[ch]),
				.load_value(pwdata),
				.limit(limit[ch]),
				.count(count[ch]),
				.hit(hit[ch])
			);

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					ctrl[ch] <= PIT_CTRL_RST;
				end else if (ctl_wr[ch]) begin
					ctrl[ch].ie <= pwdata[PIT_IE_BIT];
					ctrl[ch].nh <= pwdata[PIT_NH_BIT];
					ctrl[ch].wd <= pwdata[PIT_WD_BIT];
				end
			end

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					limit[ch] <= PIT_LIMIT_RST;
				end else if (lim_wr[ch]) begin
					limit[ch] <= pwdata;
				end
			end

			assign irq_set = hit[ch] && ctrl[ch].ie && !ctrl[ch].wd;

			// control write clears; a same-cycle hit still wins
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					irq[ch] <= 1'b0;
				end else if (irq_set) begin
					irq[ch] <= 1'b1;
				end else if (ctl_wr[ch]) begin
					irq[ch] <= 1'b0;
				end
			end

			// delay the watchdog request two cycles
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					wd_pipe <= '0;
				end else begin
					wd_pipe <= {wd_pipe[PIT_WD_DELAY-2:0], hit[ch] && ctrl[ch].wd};
				end
			end

			// Request is a one-cycle pulse per limit hit
			assign wdt_rst[ch] = wd_pipe[PIT_WD_DELAY-1];

			// ****************************************************
			// Checks
			// ****************************************************

			// Read of the control word, wait state through pready
			sequence s_ctl_read;
				rd_phase && !pwrite && ctl_sel[ch] ##1 pready;
			endsequence

			// Limit hit with the watchdog flag set
			sequence s_wd_hit;
				hit[ch] && ctrl[ch].wd;
			endsequence

			chk_wd_delay_two: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				s_wd_hit |-> ##2 wdt_rst[ch])
			else $error("watchdog request not two cycles after limit");

			chk_wd_needs_flag: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				wdt_rst[ch] |-> $past(hit[ch] && ctrl[ch].wd, 2))
			else $error("watchdog request without flag and limit");

			chk_irq_on_hit: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				hit[ch] && ctrl[ch].ie && !ctrl[ch].wd |=> irq[ch])
			else $error("interrupt missing after limit");

			chk_irq_held: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				irq[ch] && !ctl_wr[ch] |=> irq[ch])
			else $error("interrupt dropped without control write");

			chk_irq_only_wd: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				!irq[ch] && hit[ch] && ctrl[ch].wd |=> !irq[ch])
			else $error("interrupt raised with watchdog flag set");

			chk_irq_gated: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				$rose(irq[ch]) |-> $past(hit[ch] && ctrl[ch].ie))
			else $error("interrupt raised without enable");

			chk_ctl_clears_irq: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				ctl_wr[ch] && !irq_set |=> !irq[ch])
			else $error("control write left interrupt set");

			chk_ctl_keeps_count: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				ctl_wr[ch] && tick[ch] && !hit[ch]
				|=> count[ch] == PIT_DW'($past(count[ch]) + 1'b1))
			else $error("control write disturbed counting");

			chk_wrap_zero: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				hit[ch] && !cnt_wr[ch] |=> count[ch] == PIT_COUNT_RST)
			else $error("count did not restart at zero");

			chk_count_load: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				cnt_wr[ch] |=> count[ch] == $past(pwdata))
			else $error("count write not taken at once");

			chk_debug_hold: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				dbg_access && !cnt_wr[ch] |=> $stable(count[ch]))
			else $error("count moved during debug access");

			chk_halt_hold: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				ctrl[ch].nh && cpu_halted && !cnt_wr[ch] |=> $stable(count[ch]))
			else $error("count moved while halted");

			chk_free_count: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				!ctrl[ch].nh && !dbg_access && !cnt_wr[ch] && !hit[ch]
				|=> count[ch] != $past(count[ch]))
			else $error("count stalled with running flag clear");

			chk_ip_readback: assert property (
				@(posedge core_clk) disable iff (!arst_n)
				s_ctl_read |-> prdata[PIT_IP_BIT] == $past(irq[ch]))
			else $error("pending flag differs from interrupt line");
		end
	endgenerate

	// ************************************************************
	// Read data and error decode
	// ************************************************************

	logic [PIT_DW-1:0] next_prdata;
	logic next_pslverr;

	// live count and pending flag on reads
	always_comb begin
		next_prdata = PIT_RD_ZERO;
		next_pslverr = 1'b0;
		if (cnt_sel[0]) begin
			next_prdata = count[0];
		end else if (ctl_sel[0]) begin
			next_prdata[PIT_IE_BIT] = ctrl[0].ie;
			next_prdata[PIT_NH_BIT] = ctrl[0].nh;
			next_prdata[PIT_WD_BIT] = ctrl[0].wd;
			next_prdata[PIT_IP_BIT] = irq[0];
		end else if (lim_sel[0]) begin
			next_prdata = limit[0];
		end else if (cnt_sel[NUM-1]) begin
			next_prdata = count[NUM-1];
		end else if (ctl_sel[NUM-1]) begin
			next_prdata[PIT_IE_BIT] = ctrl[NUM-1].ie;
			next_prdata[PIT_NH_BIT] = ctrl[NUM-1].nh;
			next_prdata[PIT_WD_BIT] = ctrl[NUM-1].wd;
			next_prdata[PIT_IP_BIT] = irq[NUM-1];
		end else if (lim_sel[NUM-1]) begin
			next_prdata = limit[NUM-1];
		end else begin
			// Unmapped index: zero data and an error
			next_pslverr = 1'b1;
		end
	end

	// ************************************************************
	// APB answer registers
	// ************************************************************

	// One wait state gives registered read data and error
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= rd_phase;
		end
	end

	// Read data captured in the wait state, held otherwise at zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= PIT_RD_ZERO;
		end else if (rd_phase && !pwrite) begin
			prdata <= next_prdata;
		end else if (!rd_phase) begin
			prdata <= PIT_RD_ZERO;
		end
	end

	// Error flag valid alongside pready
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= rd_phase && next_pslverr;
		end
	end

	// ************************************************************
	// Bus checks
	// ************************************************************

	chk_apb_one_wait: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		rd_phase |=> pready ##1 !pready)
	else $error("pready not a one-cycle answer");

	chk_limit_write: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		lim_wr[0] |=> limit[0] == $past(pwdata))
	else $error("limit write not stored");

	// Second timer stores its limit the same way as the first
	chk_second_limit_write: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		lim_wr[NUM-1] |=> limit[NUM-1] == $past(pwdata))
	else $error("second limit write not stored");

	// Error flag only ever travels with pready
	chk_err_with_ready: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		pslverr |-> pready)
	else $error("pslverr without pready");

	// Read data is zero outside the answer cycle, so stale words never leak
	chk_idle_data_zero: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		!pready |-> prdata == PIT_RD_ZERO)
	else $error("read data not zero while idle");

	// A control write stores all three flags in one go
	chk_ctl_write_flags: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		ctl_wr[0] |=> ctrl[0].ie == $past(pwdata[PIT_IE_BIT])
			&& ctrl[0].nh == $past(pwdata[PIT_NH_BIT])
			&& ctrl[0].wd == $past(pwdata[PIT_WD_BIT]))
	else $error("control flags not stored");

endmodule
